/* File: hw/wqi_defs.svh */
/*
 * Constants of the work queue init block: bus offsets, command codes,
 * field positions, error codes and timing figures.
 * Assumes inclusion by the timer and core design files of the block and by the bench.
 */
`ifndef WQI_DEFS_SVH
`define WQI_DEFS_SVH

// Register byte offsets on the bus
`define WQI_OFS_CMD      8'h00
`define WQI_OFS_CMDOPT   8'h04
`define WQI_OFS_STATUS   8'h08
`define WQI_OFS_THAW     8'h0C
`define WQI_OFS_VECTOR   8'h10
`define WQI_OFS_LEVEL    8'h14
`define WQI_OFS_QNUM     8'h18
`define WQI_OFS_QOPT     8'h1C
`define WQI_OFS_SLOTS    8'h20
`define WQI_OFS_TMO      8'h24
`define WQI_OFS_GO       8'h28
`define WQI_OFS_DUMP     8'h2C
`define WQI_OFS_RESP     8'h30

// Command codes
`define WQI_CODE_INIT    16'h0042
`define WQI_CODE_DUMP    16'h0043

// Field positions
`define WQI_BIT_IE       0
`define WQI_BIT_AE       0
`define WQI_BIT_FZE      2
`define WQI_BIT_PE       3
`define WQI_BIT_IWQ      15
`define WQI_BIT_THAW     0
`define WQI_BIT_GO       0
`define WQI_BIT_TMO_ERR  7
`define WQI_LVL_MSB      2
`define WQI_THAW_QLSB    8

// Queue numbers
`define WQI_QNUM_MIN     16'h0001
`define WQI_QNUM_MAX     16'h000E

// Return status codes
`define WQI_ST_OK        16'h0000
`define WQI_ST_BADQ      16'h0011
`define WQI_ST_BADLVL    16'h0012
`define WQI_ST_PEND      16'h0013
`define WQI_ST_INITED    16'h0014
`define WQI_ST_BADCODE   16'h0015

// Timing and queue limit
`define WQI_CLK_HZ       20000000
`define WQI_UNIT_MS      256
`define WQI_TICK_CYCLES  (`WQI_CLK_HZ / 1000 * `WQI_UNIT_MS)
`define WQI_MAX_QUEUED   100

`endif

/* File: hw/wqi_pkg.sv */
/*
 * Types of the work queue init block: states and state records.
 * Assumes wqi_defs.svh supplies the constants.
 */
package wqi_pkg;

   // Command engine states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_EXEC = 3'h2,
      ST_DONE = 3'h4
   } wqi_fsm_t;

   // Command timer state
   typedef struct packed {
      logic        run;
      logic [23:0] div;
      logic [15:0] left;
      logic        expire;
   } wqi_tmr_t;

   // Core state
   typedef struct packed {
      logic              ack;
      logic [31:0]       rdat;
      wqi_fsm_t          fsm;
      logic [15:0]       cmdCode;
      logic [15:0]       cmdOpt;
      logic [15:0]       vec;
      logic [15:0]       lvl;
      logic [15:0]       qnum;
      logic [15:0]       qopt;
      logic [15:0]       slots;
      logic [15:0]       tmo;
      logic [15:0]       retStat;
      logic [15:0]       thaw;
      logic [31:0]       dump;
      logic [15:0]       resp;
      logic              busy;
      logic              irq;
      logic [2:0]        irqLvl;
      logic [7:0]        irqVec;
      logic              abortReq;
      logic [3:0]        abortQ;
      logic              ctrlErr;
      logic              acceptOk;
      logic [15:0]       qInit;
      logic [15:0]       qFrozen;
      logic [15:0]       qAbort;
      logic [15:0]       qFreeze;
      logic [15:0]       qParity;
      logic [15:0][15:0] qTmo;
      logic [15:0][15:0] qSlots;
      logic [15:0][7:0]  qPend;
   } wqi_state_t;

endpackage

/* File: hw/wqi_cmd_timer.sv */
/*
 * Per-command timeout timer with its own 256 ms unit divider.
 * Assumes start and stop are one-cycle pulses on core_clk.
 */
`timescale 1ns/1ps
`include "wqi_defs.svh"

module wqi_cmd_timer #(
   parameter int TICK_CYCLES = `WQI_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Control
   input  wire logic        start,
   input  wire logic        stop,
   input  wire logic [15:0] units,
   // Result
   output logic             expire
);

   // Refuse a unit the divider cannot hold
   if (TICK_CYCLES < 1 || TICK_CYCLES >= 2**24) begin : g_chk
      $error("wqi_cmd_timer: TICK_CYCLES out of range");
   end

   localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

   wqi_pkg::wqi_tmr_t s;       // Timer state
   wqi_pkg::wqi_tmr_t next_s;  // Next timer state

   // Next state of the timer
   always_comb begin
      next_s = s;
      next_s.expire = 1'b0;
      // (R14) selection starts, bus completion stops
      if (start) begin
         // (R16) zero means no timeout
         next_s.run  = (units != 16'h0000);
         next_s.left = units;
         next_s.div  = 24'h000000;
      end else if (stop) begin
         next_s.run = 1'b0;
      end else if (s.run) begin
         // (R15) one unit per full divider span
         if (s.div == TICK_LAST) begin
            next_s.div  = 24'h000000;
            next_s.left = s.left - 16'h0001;
            if (s.left == 16'h0001) begin
               next_s.run    = 1'b0;
               next_s.expire = 1'b1;
            end
         end else begin
            next_s.div = s.div + 24'h000001;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign expire = s.expire;

endmodule

/* File: hw/wqi_core.sv */
/*
 * Work queue init command engine: Wishbone register file, command
 * execution, per-queue options, freeze/thaw, abort, queue limit,
 * command timer and completion interrupt request.
 * Assumes a classic Wishbone master on core_clk and the queue
 * engine reporting enqueue, completion and selection as pulses.
 */
// The register offsets and the Wishbone slave port were left to the implementer.
// Functional notes
// (R1) Host puts code 0x42 in word zero
// (R2) Option bit 0 gates completion interrupt
// (R3) Host zeroes all reserved bits
// (R4) Low vector byte error, high byte normal
// (R5) Level 0..7; zero only without interrupt
// (R6) Host gives unique queue 1 to 14
// (R7) Abort bit flushes queue on error completion
// (R8) Freeze bit freezes queue on bad status
// (R9) Thaw register write; device clears it back
// (R10) Parity bit enables bus parity checking
// (R11) Force bit allows re-initialising a queue
// (R12) Pending commands reject init with error
// (R13) About 100 queued stops intake silently
// (R14) Timer spans selection to bus completion
// (R15) Timeout unit about 256 ms per count
// (R16) Expiry raises controller error, sets bit 7
// (R17) Return status zero ok, else error code
// (R18) Code 0x43 dumps current queue setup
// (R19) Host inits each queue separately via queue 0
// (R20) Queue 0 preset, never re-initialised
// (R21) Queue number outside 1..14 rejected
`timescale 1ns/1ps
`include "wqi_defs.svh"

module wqi_core #(
   parameter int MAX_QUEUED  = `WQI_MAX_QUEUED,
   parameter int TICK_CYCLES = `WQI_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Queue engine events
   input  wire logic        enqValid,
   input  wire logic [3:0]  enqQueue,
   input  wire logic        doneValid,
   input  wire logic [3:0]  doneQueue,
   input  wire logic        doneGood,
   input  wire logic        selDone,
   input  wire logic [3:0]  selQueue,
   input  wire logic        busDone,
   // Queue engine controls
   output logic             acceptOk,
   output logic             abortReq,
   output logic [3:0]       abortQueue,
   output logic [15:0]      frozenMask,
   output logic [15:0]      parityMask,
   // Interrupt requests
   output logic             cmpIrq,
   output logic [2:0]       cmpIrqLevel,
   output logic [7:0]       cmpIrqVector,
   output logic             ctrlErrIrq
);

   // Refuse a limit the counters cannot hold
   if (MAX_QUEUED < 1 || MAX_QUEUED > 255) begin : g_chk
      $error("wqi_core: MAX_QUEUED out of range");
   end

   localparam logic [11:0] LIMIT = 12'(MAX_QUEUED);

   wqi_pkg::wqi_state_t s;       // All state
   wqi_pkg::wqi_state_t next_s;  // Next state
   logic                tmrExp;  // Timer expiry pulse
   logic                wbReq;   // New bus request
   logic                wbWr;    // New bus write
   logic [3:0]          q;       // Queue named by the block
   logic [3:0]          tq;      // Queue named by thaw

   // Total commands held across all queues
   function automatic logic [11:0] sumPend(
      input logic [15:0][7:0] p
   );
      logic [11:0] t;
      t = 12'h000;
      for (int i = 0; i < 16; i++) begin
         t = t + {4'h0, p[i]};
      end
      return t;
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] d,
      input logic [3:0]  be
   );
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = d[7:0];
      end
      if (be[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Command timer
   wqi_cmd_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tmr (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .start    (selDone),
      .stop     (busDone),
      .units    (s.qTmo[selQueue]),
      .expire   (tmrExp)
   );

   assign wbReq = cyc_i && stb_i && !s.ack;
   assign wbWr  = wbReq && we_i;
   assign q     = s.qnum[3:0];
   assign tq    = s.thaw[`WQI_THAW_QLSB +: 4];

   // Next state of the whole block
   always_comb begin
      next_s = s;
      next_s.abortReq = 1'b0;
      next_s.ctrlErr  = 1'b0;
      // Bus answer one cycle after the request
      next_s.ack = wbReq;
      if (wbReq && !we_i) begin
         case (adr_i)
            `WQI_OFS_CMD:    next_s.rdat = {16'h0000, s.cmdCode};
            `WQI_OFS_CMDOPT: next_s.rdat = {16'h0000, s.cmdOpt};
            `WQI_OFS_STATUS: next_s.rdat = {16'h0000, s.retStat};
            `WQI_OFS_THAW:   next_s.rdat = {16'h0000, s.thaw};
            `WQI_OFS_VECTOR: next_s.rdat = {16'h0000, s.vec};
            `WQI_OFS_LEVEL:  next_s.rdat = {16'h0000, s.lvl};
            `WQI_OFS_QNUM:   next_s.rdat = {16'h0000, s.qnum};
            `WQI_OFS_QOPT:   next_s.rdat = {16'h0000, s.qopt};
            `WQI_OFS_SLOTS:  next_s.rdat = {16'h0000, s.slots};
            `WQI_OFS_TMO:    next_s.rdat = {16'h0000, s.tmo};
            `WQI_OFS_GO:     next_s.rdat = {31'h00000000, s.busy};
            `WQI_OFS_DUMP:   next_s.rdat = s.dump;
            `WQI_OFS_RESP:   next_s.rdat = {16'h0000, s.resp};
            default:         next_s.rdat = 32'h00000000;
         endcase
      end
      // Parameter words, writable while idle
      if (wbWr && !s.busy) begin
         case (adr_i)
            `WQI_OFS_CMD:    next_s.cmdCode = merge16(s.cmdCode, dat_i, sel_i);
            `WQI_OFS_CMDOPT: next_s.cmdOpt = merge16(s.cmdOpt, dat_i, sel_i);
            `WQI_OFS_VECTOR: next_s.vec = merge16(s.vec, dat_i, sel_i);
            `WQI_OFS_LEVEL:  next_s.lvl = merge16(s.lvl, dat_i, sel_i);
            `WQI_OFS_QNUM:   next_s.qnum = merge16(s.qnum, dat_i, sel_i);
            `WQI_OFS_QOPT:   next_s.qopt = merge16(s.qopt, dat_i, sel_i);
            `WQI_OFS_SLOTS:  next_s.slots = merge16(s.slots, dat_i, sel_i);
            `WQI_OFS_TMO:    next_s.tmo = merge16(s.tmo, dat_i, sel_i);
            default: ;
         endcase
      end
      // (R9) thaw request word
      if (wbWr && adr_i == `WQI_OFS_THAW) begin
         next_s.thaw = merge16(s.thaw, dat_i, sel_i);
      end
      // (R9) act on thaw, then clear as acknowledge
      if (s.thaw[`WQI_BIT_THAW]) begin
         next_s.qFrozen[tq] = 1'b0;
         next_s.thaw = 16'h0000;
      end
      // Response word: write one to clear
      if (wbWr && adr_i == `WQI_OFS_RESP && sel_i[0]) begin
         next_s.resp = s.resp & ~dat_i[15:0];
      end
      // Interrupt taken when software rewrites the status word
      if (wbWr && adr_i == `WQI_OFS_STATUS) begin
         next_s.irq = 1'b0;
      end
      // (R13) intake counted only while under the limit
      if (enqValid && s.acceptOk) begin
         next_s.qPend[enqQueue] = s.qPend[enqQueue] + 8'h01;
      end
      if (doneValid && s.qPend[doneQueue] != 8'h00) begin
         next_s.qPend[doneQueue] = next_s.qPend[doneQueue] - 8'h01;
      end
      if (doneValid && !doneGood) begin
         // (R7) flush the rest of that queue
         if (s.qAbort[doneQueue]) begin
            next_s.qPend[doneQueue] = 8'h00;
            next_s.abortReq = 1'b1;
            next_s.abortQ   = doneQueue;
         end
         // (R8) freeze that queue only; set beats thaw
         if (s.qFreeze[doneQueue]) begin
            next_s.qFrozen[doneQueue] = 1'b1;
         end
      end
      // (R16) timeout flags bit 7 and error interrupt
      if (tmrExp) begin
         next_s.resp[`WQI_BIT_TMO_ERR] = 1'b1;
         next_s.ctrlErr = 1'b1;
      end
      // Command engine
      case (s.fsm)
         wqi_pkg::ST_IDLE: begin
            if (wbWr && adr_i == `WQI_OFS_GO && dat_i[`WQI_BIT_GO]) begin
               next_s.busy = 1'b1;
               next_s.fsm  = wqi_pkg::ST_EXEC;
            end
         end
         wqi_pkg::ST_EXEC: begin
            next_s.fsm = wqi_pkg::ST_DONE;
            // (R17) zero on success, code otherwise
            next_s.retStat = `WQI_ST_OK;
            if (s.cmdCode == `WQI_CODE_INIT) begin
               // (R21) (R20) only queues 1..14 accepted
               if (s.qnum < `WQI_QNUM_MIN || s.qnum > `WQI_QNUM_MAX) begin
                  next_s.retStat = `WQI_ST_BADQ;
               // (R5) level zero only with interrupt off
               end else if (s.lvl[`WQI_LVL_MSB:0] == 3'h0 &&
                            s.cmdOpt[`WQI_BIT_IE]) begin
                  next_s.retStat = `WQI_ST_BADLVL;
               // (R12) refuse while commands pending
               end else if (s.qPend[q] != 8'h00) begin
                  next_s.retStat = `WQI_ST_PEND;
               // (R11) re-init only when forced
               end else if (s.qInit[q] && !s.qopt[`WQI_BIT_IWQ]) begin
                  next_s.retStat = `WQI_ST_INITED;
               end else begin
                  next_s.qInit[q]   = 1'b1;
                  next_s.qFrozen[q] = 1'b0;
                  next_s.qAbort[q]  = s.qopt[`WQI_BIT_AE];
                  next_s.qFreeze[q] = s.qopt[`WQI_BIT_FZE];
                  // (R10) parity check per queue
                  next_s.qParity[q] = s.qopt[`WQI_BIT_PE];
                  next_s.qTmo[q]    = s.tmo;
                  next_s.qSlots[q]  = s.slots;
               end
            // (R18) report setup of the named queue
            end else if (s.cmdCode == `WQI_CODE_DUMP) begin
               next_s.dump = {s.qTmo[q], s.qInit[q], 11'h000,
                              s.qParity[q], s.qFreeze[q], 1'b0,
                              s.qAbort[q]};
            end else begin
               next_s.retStat = `WQI_ST_BADCODE;
            end
         end
         wqi_pkg::ST_DONE: begin
            next_s.busy = 1'b0;
            next_s.fsm  = wqi_pkg::ST_IDLE;
            // (R2) interrupt only when enabled
            if (s.cmdOpt[`WQI_BIT_IE]) begin
               next_s.irq    = 1'b1;
               next_s.irqLvl = s.lvl[`WQI_LVL_MSB:0];
               // (R4) error vector low, normal vector high
               next_s.irqVec = (s.retStat == `WQI_ST_OK) ?
                               s.vec[15:8] : s.vec[7:0];
            end
         end
         default: begin
            next_s.fsm  = wqi_pkg::ST_IDLE;
            next_s.busy = 1'b0;
         end
      endcase
      // (R13) stop intake at the limit, no error
      next_s.acceptOk = sumPend(next_s.qPend) < LIMIT;
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s          <= '0;
         s.fsm      <= wqi_pkg::ST_IDLE;
         s.acceptOk <= 1'b1;
         // (R20) queue 0 ready from reset
         s.qInit    <= 16'h0001;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from state
   assign dat_o        = s.rdat;
   assign ack_o        = s.ack;
   assign acceptOk     = s.acceptOk;
   assign abortReq     = s.abortReq;
   assign abortQueue   = s.abortQ;
   assign frozenMask   = s.qFrozen;
   assign parityMask   = s.qParity;
   assign cmpIrq       = s.irq;
   assign cmpIrqLevel  = s.irqLvl;
   assign cmpIrqVector = s.irqVec;
   assign ctrlErrIrq   = s.ctrlErr;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   bus_ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held two cycles");
   thaw_clears_a: assert property ( // (R9)
      s.thaw[`WQI_BIT_THAW] |=> s.thaw == 16'h0000)
      else $error("thaw word not cleared");
   irq_vector_sel_a: assert property ( // (R4)
      s.fsm == wqi_pkg::ST_DONE && s.cmdOpt[`WQI_BIT_IE] |=>
      cmpIrq && cmpIrqVector == ((s.retStat == `WQI_ST_OK) ?
      $past(s.vec[15:8]) : $past(s.vec[7:0])))
      else $error("wrong completion vector");
   irq_gated_a: assert property ( // (R2)
      $rose(cmpIrq) |-> $past(s.cmdOpt[`WQI_BIT_IE]))
      else $error("interrupt while disabled");
   queue0_fixed_a: assert property ( // (R20)
      s.qInit[0] && !$changed(s.qTmo[0]))
      else $error("queue zero changed");
   bad_queue_a: assert property ( // (R21)
      s.fsm == wqi_pkg::ST_EXEC && s.cmdCode == `WQI_CODE_INIT &&
      (s.qnum == 16'h0000 || s.qnum > `WQI_QNUM_MAX) |=>
      s.retStat == `WQI_ST_BADQ && $stable(s.qInit))
      else $error("bad queue accepted");
   pend_reject_a: assert property ( // (R12)
      s.fsm == wqi_pkg::ST_EXEC && s.cmdCode == `WQI_CODE_INIT &&
      s.qnum >= `WQI_QNUM_MIN && s.qnum <= `WQI_QNUM_MAX &&
      s.qPend[q] != 8'h00 |=> s.retStat != `WQI_ST_OK)
      else $error("init ran with pending work");
   limit_stop_a: assert property ( // (R13)
      sumPend(s.qPend) >= LIMIT |-> !acceptOk)
      else $error("intake above limit");
   freeze_set_a: assert property ( // (R8)
      doneValid && !doneGood && s.qFreeze[doneQueue] |=>
      frozenMask[$past(doneQueue)])
      else $error("queue not frozen");
   abort_pulse_a: assert property ( // (R7)
      doneValid && !doneGood && s.qAbort[doneQueue] |=>
      abortReq && abortQueue == $past(doneQueue))
      else $error("abort not raised");
   tmo_flag_a: assert property ( // (R16)
      tmrExp |=> ctrlErrIrq && s.resp[`WQI_BIT_TMO_ERR])
      else $error("timeout not reported");

   init_ok_c: cover property (s.fsm == wqi_pkg::ST_EXEC &&
      s.cmdCode == `WQI_CODE_INIT ##1 s.retStat == `WQI_ST_OK);
   thaw_c: cover property (s.thaw[`WQI_BIT_THAW] && frozenMask != 16'h0000);
   limit_c: cover property (!acceptOk);
   tmo_c: cover property (ctrlErrIrq);

endmodule

/* File: tb/wqi_queue_model.sv */
/*
 * Queue engine model: issues enqueue, completion, selection and
 * bus-done pulses toward the core, one cycle each.
 * Assumes the bench calls its tasks on the core clock.
 */
`timescale 1ns/1ps

module wqi_queue_model (
   // Clock
   input  wire logic core_clk,
   // Event pulses toward the core
   output logic       enqValid,
   output logic [3:0] enqQueue,
   output logic       doneValid,
   output logic [3:0] doneQueue,
   output logic       doneGood,
   output logic       selDone,
   output logic [3:0] selQueue,
   output logic       busDone
);
   // Idle lines at time zero
   initial begin
      enqValid = 1'b0;
      enqQueue = 4'hF;
      doneValid = 1'b0;
      doneQueue = 4'hF;
      doneGood = 1'b0;
      selDone = 1'b0;
      selQueue = 4'hF;
      busDone = 1'b0;
   end

   task automatic enq(input logic [3:0] q);
      @(posedge core_clk);
      enqValid <= 1'b1;
      enqQueue <= q;
      @(posedge core_clk);
      enqValid <= 1'b0;
      enqQueue <= ~q;
   endtask

   task automatic done(input logic [3:0] q, input logic good);
      @(posedge core_clk);
      doneValid <= 1'b1;
      doneQueue <= q;
      doneGood <= good;
      @(posedge core_clk);
      doneValid <= 1'b0;
      doneQueue <= ~q;
      doneGood <= ~good;
   endtask

   task automatic sel(input logic [3:0] q);
      @(posedge core_clk);
      selDone <= 1'b1;
      selQueue <= q;
      @(posedge core_clk);
      selDone <= 1'b0;
      selQueue <= ~q;
   endtask

   // bus completion pulse, hit low gives none
   task automatic bus_done(input logic hit);
      @(posedge core_clk);
      busDone <= hit;
      @(posedge core_clk);
      busDone <= 1'b0;
   endtask
endmodule

/* File: tb/tb_top.sv */
/*
 * Bench of the work queue init core: Wishbone tasks, command runs
 * and queue events with expected values.
 * Assumes the queue engine model drives the event inputs.
 */
`timescale 1ns/1ps
`include "wqi_defs.svh"
`define CHK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         err_total++; \
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
      end \
   end

module tb_top;
   logic        core_clk;              // Bench clock
   logic        rst_n;                 // Sync reset
   logic        cyc, stb, we;          // Bus request
   logic [7:0]  adr;                   // Byte address
   logic [3:0]  sel;                   // Byte enables
   logic [3:0]  wbSel;                 // Lanes for the next bus cycle
   logic [31:0] datW, datR;            // Bus data
   logic        ack, acceptOk, abortReq, cmpIrq, ctrlErrIrq;
   logic [3:0]  abortQueue;            // Flushed queue
   logic [15:0] frozenMask, parityMask;
   logic [2:0]  cmpIrqLevel;           // Completion level
   logic [7:0]  cmpIrqVector;          // Completion vector
   logic        enqValid, doneValid, doneGood, selDone, busDone;
   logic [3:0]  enqQueue, doneQueue, selQueue;
   int          err_total, total_checks;

   // Clock at 50 ns
   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;

   wqi_core #(.MAX_QUEUED(4), .TICK_CYCLES(10)) wqi_core_i (
      .core_clk(core_clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
      .ack_o(ack), .enqValid(enqValid), .enqQueue(enqQueue),
      .doneValid(doneValid), .doneQueue(doneQueue), .doneGood(doneGood),
      .selDone(selDone), .selQueue(selQueue), .busDone(busDone),
      .acceptOk(acceptOk), .abortReq(abortReq), .abortQueue(abortQueue),
      .frozenMask(frozenMask), .parityMask(parityMask), .cmpIrq(cmpIrq),
      .cmpIrqLevel(cmpIrqLevel), .cmpIrqVector(cmpIrqVector),
      .ctrlErrIrq(ctrlErrIrq));

   wqi_queue_model wqi_queue_model_i (
      .core_clk(core_clk), .enqValid(enqValid), .enqQueue(enqQueue),
      .doneValid(doneValid), .doneQueue(doneQueue), .doneGood(doneGood),
      .selDone(selDone), .selQueue(selQueue), .busDone(busDone));

   // Counts, verdict, end of run
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One classic Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= wbSel;
      datW <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 50) begin
         err_total++;
         final_report();
      end
   endtask

   // Fill a parameter block, start, wait, check status and interrupt
   task automatic run(input logic [15:0] code, opt, vec, lvl, q, qo, st);
      logic [31:0] r;
      int n;
      wb(1'b1, `WQI_OFS_CMD, {16'h0000, code}, r);
      wb(1'b1, `WQI_OFS_CMDOPT, {16'h0000, opt}, r);
      wb(1'b1, `WQI_OFS_VECTOR, {16'h0000, vec}, r);
      wb(1'b1, `WQI_OFS_LEVEL, {16'h0000, lvl}, r);
      wb(1'b1, `WQI_OFS_QNUM, {16'h0000, q}, r);
      wb(1'b1, `WQI_OFS_QOPT, {16'h0000, qo}, r);
      wb(1'b1, `WQI_OFS_SLOTS, 32'h0000_0008, r);
      wb(1'b1, `WQI_OFS_TMO, 32'h0000_0002, r);
      wb(1'b1, `WQI_OFS_GO, 32'h0000_0001, r);
      n = 0;
      r = 32'h0000_0001;
      while (r[0] !== 1'b0 && n < 20) begin
         wb(1'b0, `WQI_OFS_GO, 32'h0000_0000, r);
         n++;
      end
      // Engine never went idle
      if (r[0] !== 1'b0) begin
         err_total++;
         final_report();
      end
      wb(1'b0, `WQI_OFS_STATUS, 32'h0000_0000, r);
      `CHK(r, {16'h0000, st})
      if (opt[0]) begin
         `CHK(cmpIrq, 1'b1)
         `CHK(cmpIrqLevel, lvl[2:0])
         `CHK(cmpIrqVector, (st == 16'h0000) ? vec[15:8] : vec[7:0])
      end else begin
         `CHK(cmpIrq, 1'b0)
      end
      wb(1'b1, `WQI_OFS_STATUS, 32'h0000_0000, r);
   endtask

   // Main sequence
   initial begin
      logic [31:0] r;
      int n;
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hF;
      wbSel = 4'hF;
      datW = 32'h0000_0000;
      err_total = 0;
      total_checks = 0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      `CHK(acceptOk, 1'b1)
      wb(1'b0, 8'h3C, 32'h0000_0000, r);
      `CHK(r, 32'h0000_0000)
      // Low lane only: level keeps its upper byte
      wbSel = 4'h1;
      wb(1'b1, `WQI_OFS_LEVEL, 32'h0000_FF05, r);
      wbSel = 4'hF;
      wb(1'b0, `WQI_OFS_LEVEL, 32'h0000_0000, r);
      `CHK(r, 32'h0000_0005)
      // Init, refused repeat, forced repeat, bad queues, bad level, codes
      run(16'h0042, 16'h0001, 16'hA55A, 16'h0003, 16'h0005, 16'h000D,
          16'h0000);
      `CHK(parityMask, 16'h0020)
      run(16'h0042, 16'h0001, 16'hA55A, 16'h0003, 16'h0005, 16'h000D,
          16'h0014);
      run(16'h0042, 16'h0001, 16'hA55A, 16'h0003, 16'h0005, 16'h800D,
          16'h0000);
      run(16'h0042, 16'h0001, 16'h3CC3, 16'h0002, 16'h0000, 16'h0000,
          16'h0011);
      run(16'h0042, 16'h0001, 16'h3CC3, 16'h0002, 16'h000F, 16'h0000,
          16'h0011);
      run(16'h0042, 16'h0001, 16'h3CC3, 16'h0000, 16'h0006, 16'h0000,
          16'h0012);
      run(16'h0042, 16'h0000, 16'h3CC3, 16'h0000, 16'h0007, 16'h0000,
          16'h0000);
      run(16'h0044, 16'h0001, 16'h3CC3, 16'h0007, 16'h0006, 16'h0000,
          16'h0015);
      run(16'h0043, 16'h0001, 16'h3CC3, 16'h0001, 16'h0005, 16'h0000,
          16'h0000);
      wb(1'b0, `WQI_OFS_DUMP, 32'h0000_0000, r);
      `CHK(r, 32'h0002_800D)
      // Intake limit, refused enqueue, pending blocks init
      repeat (4) wqi_queue_model_i.enq(4'h5);
      @(negedge core_clk);
      `CHK(acceptOk, 1'b0)
      wqi_queue_model_i.enq(4'h5);
      wqi_queue_model_i.done(4'h5, 1'b1);
      @(negedge core_clk);
      `CHK(acceptOk, 1'b1)
      run(16'h0042, 16'h0001, 16'hA55A, 16'h0003, 16'h0005, 16'h800D,
          16'h0013);
      // Bad completion aborts and freezes, thaw clears
      wqi_queue_model_i.done(4'h5, 1'b0);
      @(negedge core_clk);
      `CHK({abortReq, abortQueue}, 5'h15)
      `CHK(frozenMask, 16'h0020)
      @(negedge core_clk);
      `CHK(abortReq, 1'b0)
      wb(1'b1, `WQI_OFS_THAW, 32'h0000_0501, r);
      repeat (2) @(negedge core_clk);
      `CHK(frozenMask, 16'h0000)
      wb(1'b0, `WQI_OFS_THAW, 32'h0000_0000, r);
      `CHK(r, 32'h0000_0000)
      // Two-unit timeout expires
      wqi_queue_model_i.sel(4'h5);
      n = 0;
      while (ctrlErrIrq !== 1'b1 && n < 60) begin
         @(posedge core_clk);
         n++;
      end
      `CHK(n >= 19 && n <= 24, 1'b1)
      // Expiry never came
      if (n >= 60) begin
         final_report();
      end
      wb(1'b0, `WQI_OFS_RESP, 32'h0000_0000, r);
      `CHK(r, 32'h0000_0080)
      wb(1'b1, `WQI_OFS_RESP, 32'h0000_0080, r);
      wb(1'b0, `WQI_OFS_RESP, 32'h0000_0000, r);
      `CHK(r, 32'h0000_0000)
      // Bus completion stops a two-unit timer
      wqi_queue_model_i.sel(4'h5);
      repeat (5) @(posedge core_clk);
      wqi_queue_model_i.bus_done(1'b1);
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         if (ctrlErrIrq === 1'b1) n++;
      end
      `CHK(n, 0)
      // Queue 6 has a zero timeout: never fires
      wqi_queue_model_i.sel(4'h6);
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         if (ctrlErrIrq === 1'b1) n++;
      end
      `CHK(n, 0)
      final_report();
   end
endmodule
